// ---- dspacc_core.sv ----
// dspacc_core: 40-bit accumulator adder, saturation, flags, store path
// assumes: decode drives opValid/op for one cycle per instruction; operand pre-scaled
// Overview of operation
// - 40-bit adder, instruction picks target accumulator
// - add true data, carry-in 0; subtract complemented, carry-in 1
// - guard flag when bits 39:32 differ
// - guard flags per pass; trap if enabled
// - limit flags updated per pass, sticky
// - unsaturated: bit 39 overflow sets limit flag
// - either flags are OR of both accumulators
// - saturation uses enables and width select
// - 40-bit mode clamps to 40-bit extremes
// - 32-bit mode clamps; guard flags never set
// - catastrophic mode wraps, flags, traps
// - mac class writes back other accumulator
// - write-back direct or indirect with increment
// - round logic combinational, truncate if none
// - conventional round on low word >=8000
// - convergent tie uses accumulator bit 16
// - store truncated or rounded; write-back rounded
// - store clamp leaves accumulator unchanged
// - clamp stored data to 7FFF/8000
// - clamp disabled passes data unmodified
// - add/load accept barrel-shifted operand
// - separate enables for both accumulators, store
module dspacc_core
   import dspacc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // instruction decode
   input wire logic opValid,
   input wire logic [3:0] op,
   input wire logic targetSecond,
   input wire logic zeroAccSide,
   input wire logic zeroOpSide,
   input wire logic [39:0] operand,
   input wire logic wbEnable,
   input wire logic wbIndirect,
   // core control bits
   input wire logic first_acc_clamp_enable,
   input wire logic second_acc_clamp_enable,
   input wire logic clamp_width_select,
   input wire logic round_style_select,
   input wire logic store_clamp_enable,
   // trap control bits
   input wire logic fatal_overflow_trap_enable,
   input wire logic first_guard_trap_enable,
   input wire logic second_guard_trap_enable,
   // software flag clears
   input wire logic clrFirstLimit,
   input wire logic clrSecondLimit,
   // status
   output logic first_acc_guard_flag,
   output logic second_acc_guard_flag,
   output logic first_acc_limit_flag,
   output logic second_acc_limit_flag,
   output logic either_acc_guard_flag,
   output logic either_acc_limit_flag,
   output logic trapReq,
   // accumulators
   output logic [39:0] first_accumulator,
   output logic [39:0] second_accumulator,
   // x bus write
   output logic xWrite,
   output logic [15:0] xAddr,
   output logic [15:0] xData,
   output logic [15:0] writeback_pointer_reg
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      dspacc_state_e st;
      logic [1:0][39:0] acc;
      logic [1:0] guard;
      logic [1:0] limit;
      logic eitherGuard;
      logic eitherLimit;
      logic trap;
      logic xWr;
      logic [15:0] xAd;
      logic [15:0] xDa;
      logic [15:0] ptr;
   } dspacc_core_s;

   dspacc_core_s state_q;
   dspacc_core_s state_d;

   dspacc_rnd_if rndIf ();

   dspacc_round u_round (
      .port(rndIf.rnd)
   );

   // ----------------------------------------
   // adder and saturation
   // ----------------------------------------
   logic tgt;
   logic isAdd;
   logic isSub;
   logic isLoad;
   logic isMulClass;
   logic isStore;
   logic passes;
   logic [39:0] srcAcc;
   logic [39:0] sideA;
   logic [39:0] sideB;
   logic carryIn;
   logic [40:0] sum;
   logic [39:0] res;
   logic ovf39;
   logic ovf31;
   logic guardHit;
   logic satEn;
   logic [39:0] finalVal;
   logic limitHit;
   logic [1:0] guardTe;

   always_comb begin
      tgt = targetSecond;
      isAdd = op == OP_ADD || op == OP_MULACC || op == OP_MULT || op == OP_DIST || op == OP_DISTACC;
      isSub = op == OP_SUB || op == OP_MULSUB || op == OP_MULNEG;
      isLoad = op == OP_LOAD;
      isMulClass = op == OP_MULACC || op == OP_MULSUB;
      isStore = op == OP_STORE || op == OP_STORERND;
      passes = opValid && (isAdd || isSub || isLoad);
      srcAcc = state_q.acc[tgt];
      // plain multiply, load and distance start from zero
      sideA = (zeroAccSide || isLoad || op == OP_MULT || op == OP_MULNEG || op == OP_DIST)
         ? ACC_RESET : srcAcc;
      // operand already scaled by the barrel shifter for add and load
      sideB = zeroOpSide ? ACC_RESET : operand;
      carryIn = 1'b0;
      if (isSub) begin
         sideB = ~sideB;
         carryIn = 1'b1;
      end
      sum = {1'b0, sideA} + {1'b0, sideB} + {40'h00_0000_0000, carryIn};
      res = sum[39:0];
      ovf39 = (sideA[SIGN40] == sideB[SIGN40]) && (res[SIGN40] != sideA[SIGN40]);
      ovf31 = res[39:SIGN32] != {9{res[SIGN40]}};
      guardHit = res[39:GUARD_LO] != {8{res[SIGN40]}};
      satEn = tgt ? second_acc_clamp_enable : first_acc_clamp_enable;
      finalVal = res;
      limitHit = ovf39;
      if (satEn && !clamp_width_select) begin
         if (ovf39) begin
            finalVal = sideA[SIGN40] ? MIN40 : MAX40;
         end
      end else if (satEn && clamp_width_select) begin
         limitHit = ovf39 || ovf31;
         if (limitHit) begin
            finalVal = (ovf39 ? sideA[SIGN40] : res[SIGN40]) ? MIN32 : MAX32;
         end
         guardHit = 1'b0;
      end
      // catastrophic mode: finalVal stays wrapped
      guardTe = {second_guard_trap_enable, first_guard_trap_enable};
   end

   // ----------------------------------------
   // round and store hookup
   // ----------------------------------------
   always_comb begin
      rndIf.acc = isStore ? state_q.acc[tgt] : state_q.acc[~tgt];
      rndIf.doRound = op != OP_STORE;
      rndIf.convergent = round_style_select;
      rndIf.clampEn = store_clamp_enable;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      state_d.st = opValid ? ST_BUSY : ST_IDLE;
      state_d.trap = 1'b0;
      state_d.xWr = 1'b0;
      // software clear, set below wins
      if (clrFirstLimit) state_d.limit[0] = 1'b0;
      if (clrSecondLimit) state_d.limit[1] = 1'b0;
      if (passes) begin
         state_d.acc[tgt] = finalVal;
         state_d.guard[tgt] = guardHit;
         if (limitHit) begin
            state_d.limit[tgt] = 1'b1;
         end
         state_d.trap = (guardHit && guardTe[tgt])
            || (limitHit && !satEn && fatal_overflow_trap_enable);
      end
      if (opValid && isMulClass && wbEnable) begin
         state_d.xDa = rndIf.result;
         if (wbIndirect) begin
            state_d.xWr = 1'b1;
            state_d.xAd = state_q.ptr;
            state_d.ptr = state_q.ptr + PTR_STEP;
         end else begin
            state_d.ptr = rndIf.result;
         end
      end else if (opValid && isStore) begin
         state_d.xWr = 1'b1;
         state_d.xAd = state_q.ptr;
         state_d.xDa = rndIf.result;
      end
      state_d.eitherGuard = state_d.guard[0] | state_d.guard[1];
      state_d.eitherLimit = state_d.limit[0] | state_d.limit[1];
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_q <= '{st: ST_IDLE, acc: {ACC_RESET, ACC_RESET}, ptr: PTR_RESET, default: '0};
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign first_acc_guard_flag = state_q.guard[0];
   assign second_acc_guard_flag = state_q.guard[1];
   assign first_acc_limit_flag = state_q.limit[0];
   assign second_acc_limit_flag = state_q.limit[1];
   assign either_acc_guard_flag = state_q.eitherGuard;
   assign either_acc_limit_flag = state_q.eitherLimit;
   assign trapReq = state_q.trap;
   assign first_accumulator = state_q.acc[0];
   assign second_accumulator = state_q.acc[1];
   assign xWrite = state_q.xWr;
   assign xAddr = state_q.xAd;
   assign xData = state_q.xDa;
   assign writeback_pointer_reg = state_q.ptr;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_satPass(w);
      opValid && (isAdd || isSub) && satEn && clamp_width_select == w && ovf39;
   endsequence

   // write-back request, one per addressing mode
   sequence s_wbIndirect;
      opValid && isMulClass && wbEnable && wbIndirect;
   endsequence

   sequence s_wbDirect;
      opValid && isMulClass && wbEnable && !wbIndirect;
   endsequence

   AST_SAT40: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_satPass(1'b0) |=> (state_q.acc[$past(tgt)] == MAX40 || state_q.acc[$past(tgt)] == MIN40))
      else $error("40-bit saturation value wrong");
   AST_GUARD32: assert property (@(posedge ref_clk) disable iff (!rst_b)
      passes && satEn && clamp_width_select |=> !state_q.guard[$past(tgt)])
      else $error("guard flag set in 32-bit mode");
   AST_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_b)
      state_q.limit[0] && !clrFirstLimit |=> state_q.limit[0])
      else $error("limit flag cleared by hardware");
   AST_SETWINS: assert property (@(posedge ref_clk) disable iff (!rst_b)
      passes && !tgt && limitHit && clrFirstLimit |=> state_q.limit[0])
      else $error("clear beat same-cycle set");
   AST_EITHER: assert property (@(posedge ref_clk) disable iff (!rst_b)
      either_acc_limit_flag == (first_acc_limit_flag | second_acc_limit_flag))
      else $error("combined limit flag mismatch");
   AST_CATTRAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
      passes && !satEn && ovf39 && fatal_overflow_trap_enable |=> trapReq)
      else $error("catastrophic trap missing");
   AST_PTRINC: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_wbIndirect |=> xWrite && writeback_pointer_reg == xAddr + PTR_STEP)
      else $error("write-back pointer not stepped");
   AST_STORECLAMP: assert property (@(posedge ref_clk) disable iff (!rst_b)
      opValid && isStore |=> state_q.acc == $past(state_q.acc))
      else $error("store changed accumulator");
   AST_STOREOUT: assert property (@(posedge ref_clk) disable iff (!rst_b)
      opValid && isStore |=> xWrite && xData == $past(rndIf.result) && xAddr == $past(state_q.ptr))
      else $error("store word or address wrong");
   AST_DIRECTWB: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_wbDirect |=> !xWrite && writeback_pointer_reg == $past(rndIf.result))
      else $error("direct write-back wrong");
   AST_NOWB: assert property (@(posedge ref_clk) disable iff (!rst_b)
      opValid && !isMulClass && !isStore |=> !xWrite)
      else $error("stray data space write");
   AST_GUARDSET: assert property (@(posedge ref_clk) disable iff (!rst_b)
      passes && !(satEn && clamp_width_select) && res[39:GUARD_LO] != {8{res[SIGN40]}}
      |=> state_q.guard[$past(tgt)])
      else $error("guard flag not set");
   AST_GUARDTRAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
      passes && guardHit && guardTe[tgt] |=> trapReq)
      else $error("guard trap missing");
   AST_SAT32: assert property (@(posedge ref_clk) disable iff (!rst_b)
      passes && satEn && clamp_width_select && (ovf39 || ovf31)
      |=> (state_q.acc[$past(tgt)] == MAX32 || state_q.acc[$past(tgt)] == MIN32) && state_q.limit[$past(tgt)])
      else $error("32-bit saturation wrong");
   AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
      passes && !satEn |=> state_q.acc[$past(tgt)] == $past(res))
      else $error("unsaturated result altered");
   AST_OTHERKEPT: assert property (@(posedge ref_clk) disable iff (!rst_b)
      passes |=> state_q.acc[!$past(tgt)] == $past(state_q.acc[!tgt]))
      else $error("non-target accumulator changed");
   AST_STICKYB: assert property (@(posedge ref_clk) disable iff (!rst_b)
      state_q.limit[1] && !clrSecondLimit |=> state_q.limit[1])
      else $error("second limit flag cleared by hardware");
   AST_EITHERG: assert property (@(posedge ref_clk) disable iff (!rst_b)
      either_acc_guard_flag == (first_acc_guard_flag | second_acc_guard_flag))
      else $error("combined guard flag mismatch");
endmodule

// ---- dspacc_pkg.sv ----
// dspacc_pkg: constants and types for the dsp accumulator datapath
// assumes: used by dspacc_core, dspacc_round, dspacc_rnd_if
package dspacc_pkg;
   localparam int ACC_W = 40;
   localparam int WORD_W = 16;
   localparam int GUARD_LO = 32;
   localparam int SIGN40 = 39;
   localparam int SIGN32 = 31;
   localparam int HI_LO = 16;
   localparam int HI_HI = 31;
   localparam logic [39:0] MAX40 = 40'h7F_FFFF_FFFF;
   localparam logic [39:0] MIN40 = 40'h80_0000_0000;
   localparam logic [39:0] MAX32 = 40'h00_7FFF_FFFF;
   localparam logic [39:0] MIN32 = 40'hFF_8000_0000;
   localparam logic [15:0] HALF_LSW = 16'h8000;
   localparam logic [15:0] POS_MAX16 = 16'h7FFF;
   localparam logic [15:0] NEG_MAX16 = 16'h8000;
   localparam logic [15:0] PTR_STEP = 16'h0002;
   localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
   localparam logic [15:0] PTR_RESET = 16'h0000;

   // operation codes from instruction decode
   typedef enum logic [3:0] {
      OP_NONE = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_LOAD = 4'h3,
      OP_MULACC = 4'h4, OP_MULSUB = 4'h5, OP_MULT = 4'h6, OP_MULNEG = 4'h7,
      OP_DIST = 4'h8, OP_DISTACC = 4'h9, OP_STORE = 4'hA, OP_STORERND = 4'hB
   } dspacc_op_e;

   // pipeline states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01, ST_BUSY = 2'b10
   } dspacc_state_e;
endpackage

// ---- dspacc_rnd_if.sv ----
// dspacc_rnd_if: carries an accumulator into the round/store clamp and back
// assumes: one clock, combinational producer
interface dspacc_rnd_if;
   import dspacc_pkg::*;
   logic [39:0] acc;
   logic doRound;
   logic convergent;
   logic clampEn;
   logic [15:0] result;
   modport core (output acc, output doRound, output convergent, output clampEn, input result);
   modport rnd (input acc, input doRound, input convergent, input clampEn, output result);
endinterface

// ---- dspacc_round.sv ----
// dspacc_round: combinational round to 1.15 plus store clamp
// assumes: inputs are stable within the cycle
module dspacc_round
   import dspacc_pkg::*;
(
   // link to core
   dspacc_rnd_if.rnd port
);
   logic [15:0] hiWord;
   logic [15:0] loWord;
   logic inc;
   logic [16:0] sum;
   logic [24:0] full;

   always_comb begin
      hiWord = port.acc[HI_HI:HI_LO];
      loWord = port.acc[HI_LO-1:0];
      inc = 1'b0;
      if (port.doRound) begin
         inc = loWord[WORD_W-1];
         if (port.convergent && loWord == HALF_LSW) begin
            inc = port.acc[HI_LO];
         end
      end
      sum = {1'b0, hiWord} + {16'h0000, inc};
      // sign from bit 39, round carry lands in the integer part
      full = {port.acc[SIGN40], port.acc[SIGN40:HI_LO]} + {24'h00_0000, inc};
      port.result = sum[15:0];
      if (port.clampEn) begin
         if (!port.acc[SIGN40] && full[24:15] != 10'h000) begin
            port.result = POS_MAX16;
         end else if (port.acc[SIGN40] && full[24:15] != 10'h3FF) begin
            port.result = NEG_MAX16;
         end
      end
   end
endmodule

// ---- dspacc_xbus_model.sv ----
// dspacc_xbus_model: x data bus memory side and trap sink
// assumes: writes and trap requests are one-cycle pulses on ref_clk
module dspacc_xbus_model (
   // clock
   input wire logic ref_clk,
   // from the datapath
   input wire logic xWrite,
   input wire logic [15:0] xAddr,
   input wire logic [15:0] xData,
   input wire logic trapReq,
   // seen traffic
   output int writes,
   output int traps,
   output logic [15:0] lastAddr,
   output logic [15:0] lastData
);
   timeunit 1ns;
   timeprecision 1ps;
   // one process owns every output; counting pulses tells a held pulse from a single one
   initial begin
      writes = 0;
      traps = 0;
      lastAddr = 16'h0000;
      lastData = 16'h0000;
      forever begin
         @(posedge ref_clk);
         if (xWrite === 1'b1) begin
            writes <= writes + 1;
            lastAddr <= xAddr;
            lastData <= xData;
         end
         if (trapReq === 1'b1) begin
            traps <= traps + 1;
         end
      end
   end
endmodule

// ---- tb_top.sv ----
// tb_top: self-checking bench for the accumulator datapath
// assumes: dspacc_core answers one cycle after the taking edge
module tb_top
   import dspacc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_b, opValid, targetSecond, zeroAccSide, wbEnable, wbIndirect;
   logic [3:0] op;
   logic [39:0] operand, fa, sa;
   logic faClamp, saClamp, widthSel, rndStyle, stClamp, covTrap, gaTrap, gbTrap, clrA, clrB, zeroOp;
   logic gFa, gSa, lFa, lSa, gAny, lAny, trapReq, xWrite;
   logic [15:0] xAddr, xData, wbPtr, lastAddr, lastData;
   int writes, traps, w0, t0, miscompares, tests_run;
   dspacc_core dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .opValid(opValid), .op(op),
      .targetSecond(targetSecond), .zeroAccSide(zeroAccSide), .zeroOpSide(zeroOp), .operand(operand),
      .wbEnable(wbEnable), .wbIndirect(wbIndirect), .first_acc_clamp_enable(faClamp),
      .second_acc_clamp_enable(saClamp), .clamp_width_select(widthSel), .round_style_select(rndStyle),
      .store_clamp_enable(stClamp), .fatal_overflow_trap_enable(covTrap), .first_guard_trap_enable(gaTrap),
      .second_guard_trap_enable(gbTrap), .clrFirstLimit(clrA), .clrSecondLimit(clrB),
      .first_acc_guard_flag(gFa), .second_acc_guard_flag(gSa), .first_acc_limit_flag(lFa),
      .second_acc_limit_flag(lSa), .either_acc_guard_flag(gAny), .either_acc_limit_flag(lAny),
      .trapReq(trapReq), .first_accumulator(fa), .second_accumulator(sa), .xWrite(xWrite),
      .xAddr(xAddr), .xData(xData), .writeback_pointer_reg(wbPtr));
   dspacc_xbus_model xbus_u (.ref_clk(ref_clk), .xWrite(xWrite), .xAddr(xAddr), .xData(xData),
      .trapReq(trapReq), .writes(writes), .traps(traps), .lastAddr(lastAddr), .lastData(lastData));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // one instruction, then room for the registered answer and its pulses
   task automatic do_op(input logic [3:0] o, input logic tgt, input logic [39:0] v);
      @(negedge ref_clk);
      op = o;
      targetSecond = tgt;
      operand = v;
      zeroAccSide = (o == OP_LOAD);
      opValid = 1'b1;
      w0 = writes;
      t0 = traps;
      @(negedge ref_clk);
      opValid = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask
   // ------------------------------------------------------------
   // clock, watchdog
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      #(5000 * 50);
      miscompares++;
      close_out();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      miscompares = 0;
      tests_run = 0;
      {opValid, targetSecond, zeroAccSide, wbEnable, wbIndirect, faClamp, saClamp} = 7'h00;
      {widthSel, rndStyle, stClamp, covTrap, gaTrap, gbTrap, clrA} = 7'h00;
      {zeroOp, clrB} = 2'b00;
      op = OP_NONE;
      operand = 40'h00_0000_0000;
      rst_b = 1'b0;
      repeat (20) @(negedge ref_clk);
      rst_b = 1'b1;
      chk(fa, ACC_RESET);
      chk(40'(lAny), 40'h0);
      gaTrap = 1'b1;
      covTrap = 1'b1;
      do_op(OP_LOAD, 1'b0, 40'h00_8000_0000);
      do_op(OP_ADD, 1'b0, 40'h00_8000_0000);
      chk(fa, 40'h01_0000_0000);
      chk(40'(gFa), 40'h1);
      chk(40'(gAny), 40'h1);
      chk(40'(traps - t0), 40'h1);
      chk(40'(lFa), 40'h0);
      do_op(OP_LOAD, 1'b0, MAX40);
      do_op(OP_ADD, 1'b0, 40'h00_0000_0001);
      chk(fa, MIN40);
      chk(40'(lFa), 40'h1);
      chk(40'(lAny), 40'h1);
      chk(40'(traps - t0), 40'h1);
      do_op(OP_SUB, 1'b0, MIN40);
      chk(40'(gFa), 40'h0);
      chk(40'(lFa), 40'h1);
      @(negedge ref_clk);
      clrA = 1'b1;
      @(negedge ref_clk);
      clrA = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(40'(lFa), 40'h0);
      {covTrap, gaTrap, faClamp, widthSel} = 4'b0010;
      do_op(OP_LOAD, 1'b0, MAX40);
      do_op(OP_ADD, 1'b0, 40'h00_0000_0001);
      chk(fa, MAX40);
      chk(40'(lFa), 40'h1);
      do_op(OP_LOAD, 1'b0, MIN40);
      do_op(OP_SUB, 1'b0, 40'h00_0000_0001);
      chk(fa, MIN40);
      {faClamp, saClamp, widthSel} = 3'b011;
      do_op(OP_LOAD, 1'b1, MAX32);
      do_op(OP_ADD, 1'b1, 40'h00_0000_0001);
      chk(sa, MAX32);
      chk(40'(lSa), 40'h1);
      chk(40'(gSa), 40'h0);
      do_op(OP_LOAD, 1'b1, MIN32);
      do_op(OP_SUB, 1'b1, 40'h00_0000_0001);
      chk(sa, MIN32);
      // stores from the first accumulator, address is the pointer
      do_op(OP_LOAD, 1'b0, 40'h00_1234_8000);
      do_op(OP_STORE, 1'b0, 40'h0);
      chk(40'(lastData), 40'h1234);
      chk(40'(lastAddr), 40'(PTR_RESET));
      do_op(OP_STORERND, 1'b0, 40'h0);
      chk(40'(lastData), 40'h1235);
      rndStyle = 1'b1;
      do_op(OP_STORERND, 1'b0, 40'h0);
      chk(40'(lastData), 40'h1234);
      do_op(OP_LOAD, 1'b0, 40'h00_1235_8000);
      do_op(OP_STORERND, 1'b0, 40'h0);
      chk(40'(lastData), 40'h1236);
      stClamp = 1'b1;
      do_op(OP_LOAD, 1'b0, 40'h01_0000_0000);
      do_op(OP_STORE, 1'b0, 40'h0);
      chk(40'(lastData), 40'(POS_MAX16));
      chk(fa, 40'h01_0000_0000);
      do_op(OP_LOAD, 1'b0, 40'hFE_0000_0000);
      do_op(OP_STORE, 1'b0, 40'h0);
      chk(40'(lastData), 40'(NEG_MAX16));
      stClamp = 1'b0;
      do_op(OP_STORE, 1'b0, 40'h0);
      chk(40'(lastData), 40'h0000);
      // write-back of the other accumulator
      {rndStyle, wbEnable, wbIndirect} = 3'b011;
      do_op(OP_LOAD, 1'b1, 40'h00_2345_8000);
      do_op(OP_MULACC, 1'b0, 40'h0);
      chk(40'(writes - w0), 40'h1);
      chk(40'(lastData), 40'h2346);
      chk(40'(lastAddr), 40'h0000);
      chk(40'(wbPtr), 40'(PTR_STEP));
      wbIndirect = 1'b0;
      do_op(OP_MULSUB, 1'b0, 40'h0);
      chk(40'(wbPtr), 40'h2346);
      chk(40'(writes - w0), 40'h0);
      wbIndirect = 1'b1;
      do_op(OP_MULT, 1'b0, 40'h0);
      chk(40'(writes - w0), 40'h0);
      // remaining decodes, forced-zero operand side
      zeroOp = 1'b1;
      do_op(OP_ADD, 1'b0, 40'h00_0000_0077);
      zeroOp = 1'b0;
      chk(fa, 40'h00_0000_0000);
      do_op(OP_MULNEG, 1'b0, 40'h00_0000_0005);
      chk(fa, 40'hFF_FFFF_FFFB);
      chk(40'(writes - w0), 40'h0);
      do_op(OP_DISTACC, 1'b0, 40'h00_0000_0003);
      chk(fa, 40'hFF_FFFF_FFFE);
      chk(40'(writes - w0), 40'h0);
      do_op(OP_DIST, 1'b0, 40'h00_0000_0009);
      chk(fa, 40'h00_0000_0009);
      chk(40'(writes - w0), 40'h0);
      // second limit clear, first still holds the combined flag
      @(negedge ref_clk);
      clrB = 1'b1;
      @(negedge ref_clk);
      clrB = 1'b0;
      chk(40'(lSa), 40'h0);
      chk(40'(lAny), 40'h1);
      {saClamp, gbTrap} = 2'b01;
      do_op(OP_ADD, 1'b1, 40'h01_0000_0000);
      chk(40'(gSa), 40'h1);
      chk(40'(traps - t0), 40'h1);
      // clear in the same cycle as an overflow: the set must win
      do_op(OP_LOAD, 1'b0, MAX40);
      @(negedge ref_clk);
      op = OP_ADD;
      operand = 40'h00_0000_0001;
      zeroAccSide = 1'b0;
      opValid = 1'b1;
      clrA = 1'b1;
      @(negedge ref_clk);
      opValid = 1'b0;
      clrA = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(40'(lFa), 40'h1);
      chk(fa, MIN40);
      close_out();
   end
endmodule
